// ===== shared/rtc_pkg.sv
package rtc_pkg;
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_CTRL      = 6'h00;
    localparam logic [5:0] IDX_STATUS    = 6'h01;
    localparam logic [5:0] IDX_IRQ_EN    = 6'h02;
    localparam logic [5:0] IDX_IRQ_FLAG  = 6'h03;
    localparam logic [5:0] IDX_SRC       = 6'h07;
    localparam logic [5:0] IDX_CNT_LO    = 6'h08;
    localparam logic [5:0] IDX_CNT_HI    = 6'h09;
    localparam logic [5:0] IDX_TOP_LO    = 6'h0A;
    localparam logic [5:0] IDX_TOP_HI    = 6'h0B;
    localparam logic [5:0] IDX_MATCH_LO  = 6'h0C;
    localparam logic [5:0] IDX_MATCH_HI  = 6'h0D;
    localparam logic [5:0] IDX_PIT_CTRL  = 6'h10;
    localparam logic [5:0] IDX_PIT_STAT  = 6'h11;
    localparam logic [5:0] IDX_PIT_IEN   = 6'h12;
    localparam logic [5:0] IDX_PIT_FLAG  = 6'h13;
    localparam logic [5:0] IDX_PIT_DBG   = 6'h15;

    // field positions
    localparam int unsigned BIT_WRAP     = 0;
    localparam int unsigned BIT_MATCH    = 1;
    localparam int unsigned BIT_PIT_ON   = 0;
    localparam int unsigned PIT_IV_LSB   = 3;
    localparam int unsigned PIT_IV_MSB   = 6;

    // sync channels, also the busy bit order in the status register for count, top and match; periodic busy is bit 0 of the periodic status
    localparam int unsigned CH_PIT       = 0;
    localparam int unsigned CH_CNT       = 1;
    localparam int unsigned CH_TOP       = 2;
    localparam int unsigned CH_MATCH     = 3;
    localparam int unsigned NUM_CH       = 4;

    // reset values
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam logic [15:0] TOP_RST      = 16'hFFFF;
    localparam logic [15:0] MATCH_RST    = 16'h0000;

    // counter clock source codes
    localparam logic [1:0] SRC_INT_FAST  = 2'h0;
    localparam logic [1:0] SRC_INT_SLOW  = 2'h1;
    localparam logic [1:0] SRC_CRYSTAL   = 2'h2;
    localparam logic [1:0] SRC_EXT_PIN   = 2'h3;

    // periodic interval codes
    localparam logic [3:0] IV_OFF        = 4'h0;
    localparam logic [3:0] IV_MAX        = 4'hE;

    // counter-clock ticks from a bus write until it takes effect
    localparam logic [1:0] SYNC_LAT      = 2'h2;

    typedef struct packed {
        logic [3:0] interval;
        logic       on;
    } rtc_pit_ctrl_s;
endpackage

// ===== hw/rtc_top.sv
`timescale 1ns/1ps
// What this block does
// - two-bit source field picks one of four counter clock inputs
// - count, top and match are 16 bits, low and high bytes adjacent
// - count write takes effect after two counter ticks; busy until then
// - top write takes effect after two counter ticks; busy until then
// - top register is read/write and resets to all ones
// - match and count registers are read/write and reset to zero
// - interval code picks 4 to 32768 ticks; zero gives no event
// - periodic timer control bit 0 switches the periodic timer on
// - periodic status bit 0 shows a control write still syncing
// - periodic irq enable bit 0 lets the periodic flag raise irq
// - periodic flag set per event, cleared by writing one
// - periodic timer halts in debug halt unless run bit is set
// - count equal to top wraps to zero and sets wrap flag
// - counter advances only while counter_on is set
module rtc_top #(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned DIV_W  = 15
) (
    input  wire logic              pclk,        // bus clock, 20 MHz
    input  wire logic              presetn,     // async reset, active low
    input  wire logic              psel,        // apb select
    input  wire logic              penable,     // apb access phase
    input  wire logic              pwrite,      // apb direction
    input  wire logic [ADDR_W-1:0] paddr,       // apb byte address
    input  wire logic [31:0]       pwdata,      // apb write data
    output logic      [31:0]       prdata,      // apb read data
    output logic                   pready,      // apb ready
    output logic                   pslverr,     // apb error, unmapped
    input  wire logic [3:0]        osc_clk_in,  // raw source clocks
    input  wire logic              debug_halt,  // cpu in break debug
    output logic                   irq          // level interrupt
);
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [3:0]          src_s1_reg;
    logic [3:0]          src_s2_reg;
    logic [3:0]          src_s3_reg;
    logic [1:0]          src_sel_reg;
    logic                counter_on_reg;
    logic [1:0]          irq_en_reg;
    logic [1:0]          flag_reg;
    logic [15:0]         cnt_sh_reg;
    logic [15:0]         top_sh_reg;
    logic [15:0]         match_sh_reg;
    logic [15:0]         count_reg;
    logic [15:0]         top_act_reg;
    logic [15:0]         match_act_reg;
    rtc_pit_ctrl_s       pit_sh_reg;
    rtc_pit_ctrl_s       pit_act_reg;
    logic                pit_ien_reg;
    logic                pit_flag_reg;
    logic                run_halt_reg;
    logic [DIV_W-1:0]    div_reg;
    logic [NUM_CH-1:0]   busy_reg;
    logic [1:0]          lat_reg [NUM_CH];
    logic [NUM_CH-1:0]   chan_wr;
    logic [NUM_CH-1:0]   apply;
    logic [31:0]         prdata_reg;
    logic                pslverr_reg;
    logic                irq_reg;
    logic [31:0]         rd_word;
    logic                rd_hit;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic at(input logic [5:0] a, input logic [5:0] w);
        return a == w;
    endfunction

    // mask of the low divider bits for a given interval code
    function automatic logic [DIV_W-1:0] iv_mask(input logic [3:0] iv);
        logic [15:0] m;
        m = (16'h0002 << iv) - 16'h0001;
        return m[DIV_W-1:0];
    endfunction

    // ------------------------------------------------------------
    // counter clock source
    // ------------------------------------------------------------
    // sources are pin-level clocks far slower than pclk, so each is
    // sampled twice and a rising edge becomes a one-cycle tick enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_s1_reg <= 4'h0;
            src_s2_reg <= 4'h0;
            src_s3_reg <= 4'h0;
        end else begin
            src_s1_reg <= osc_clk_in;
            src_s2_reg <= src_s1_reg;
            src_s3_reg <= src_s2_reg;
        end
    end

    wire [3:0] src_rise = src_s2_reg & ~src_s3_reg;
    wire       src_tick = src_rise[src_sel_reg];
    wire       cnt_tick = src_tick & counter_on_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire [5:0] idx     = paddr[7:2];
    wire       aligned = paddr[1:0] == 2'b00;
    wire       setup   = psel & ~penable;
    wire       wr_en   = psel & penable & pwrite & ~pslverr_reg;
    wire [7:0] wb      = pwdata[7:0];

    wire w_ctrl   = wr_en & at(idx, IDX_CTRL);
    wire w_ien    = wr_en & at(idx, IDX_IRQ_EN);
    wire w_flag   = wr_en & at(idx, IDX_IRQ_FLAG);
    wire w_src    = wr_en & at(idx, IDX_SRC);
    wire w_cnt_l  = wr_en & at(idx, IDX_CNT_LO);
    wire w_cnt_h  = wr_en & at(idx, IDX_CNT_HI);
    wire w_top_l  = wr_en & at(idx, IDX_TOP_LO);
    wire w_top_h  = wr_en & at(idx, IDX_TOP_HI);
    wire w_mat_l  = wr_en & at(idx, IDX_MATCH_LO);
    wire w_mat_h  = wr_en & at(idx, IDX_MATCH_HI);
    wire w_pit    = wr_en & at(idx, IDX_PIT_CTRL);
    wire w_pien   = wr_en & at(idx, IDX_PIT_IEN);
    wire w_pflag  = wr_en & at(idx, IDX_PIT_FLAG);
    wire w_dbg    = wr_en & at(idx, IDX_PIT_DBG);

    assign chan_wr[CH_PIT]   = w_pit;
    assign chan_wr[CH_CNT]   = w_cnt_l | w_cnt_h;
    assign chan_wr[CH_TOP]   = w_top_l | w_top_h;
    assign chan_wr[CH_MATCH] = w_mat_l | w_mat_h;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = aligned;
        if (at(idx, IDX_CTRL)) begin
            rd_word[0] = counter_on_reg;
        end else if (at(idx, IDX_STATUS)) begin
            rd_word[3:1] = busy_reg[CH_MATCH:CH_CNT];
        end else if (at(idx, IDX_IRQ_EN)) begin
            rd_word[1:0] = irq_en_reg;
        end else if (at(idx, IDX_IRQ_FLAG)) begin
            rd_word[1:0] = flag_reg;
        end else if (at(idx, IDX_SRC)) begin
            rd_word[1:0] = src_sel_reg;
        end else if (at(idx, IDX_CNT_LO)) begin
            rd_word[7:0] = count_reg[7:0];
        end else if (at(idx, IDX_CNT_HI)) begin
            rd_word[7:0] = count_reg[15:8];
        end else if (at(idx, IDX_TOP_LO)) begin
            rd_word[7:0] = top_sh_reg[7:0];
        end else if (at(idx, IDX_TOP_HI)) begin
            rd_word[7:0] = top_sh_reg[15:8];
        end else if (at(idx, IDX_MATCH_LO)) begin
            rd_word[7:0] = match_sh_reg[7:0];
        end else if (at(idx, IDX_MATCH_HI)) begin
            rd_word[7:0] = match_sh_reg[15:8];
        end else if (at(idx, IDX_PIT_CTRL)) begin
            rd_word[PIT_IV_MSB:PIT_IV_LSB] = pit_sh_reg.interval;
            rd_word[BIT_PIT_ON] = pit_sh_reg.on;
        end else if (at(idx, IDX_PIT_STAT)) begin
            rd_word[0] = busy_reg[CH_PIT];
        end else if (at(idx, IDX_PIT_IEN)) begin
            rd_word[0] = pit_ien_reg;
        end else if (at(idx, IDX_PIT_FLAG)) begin
            rd_word[0] = pit_flag_reg;
        end else if (at(idx, IDX_PIT_DBG)) begin
            rd_word[0] = run_halt_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // answer is prepared in the setup cycle so the access phase
    // completes with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= rd_hit ? rd_word : 32'h0000_0000;
            pslverr_reg <= ~rd_hit;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg & psel & penable;
    assign pready  = 1'b1;

    // ------------------------------------------------------------
    // plain control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_on_reg <= 1'b0;
            src_sel_reg    <= SRC_INT_FAST;
            irq_en_reg     <= 2'b00;
            pit_ien_reg    <= 1'b0;
            run_halt_reg   <= 1'b0;
        end else begin
            if (w_ctrl)
                counter_on_reg <= wb[0];
            if (w_src)
                src_sel_reg <= wb[1:0];
            if (w_ien)
                irq_en_reg <= wb[1:0];
            if (w_pien)
                pit_ien_reg <= wb[0];
            if (w_dbg)
                run_halt_reg <= wb[0];
        end
    end

    // ------------------------------------------------------------
    // bus-side shadows of the 16-bit values and the periodic timer control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_sh_reg   <= CNT_RST;
            top_sh_reg   <= TOP_RST;
            match_sh_reg <= MATCH_RST;
            pit_sh_reg   <= '0;
        end else begin
            if (w_cnt_l) cnt_sh_reg[7:0]    <= wb;
            if (w_cnt_h) cnt_sh_reg[15:8]   <= wb;
            if (w_top_l) top_sh_reg[7:0]    <= wb;
            if (w_top_h) top_sh_reg[15:8]   <= wb;
            if (w_mat_l) match_sh_reg[7:0]  <= wb;
            if (w_mat_h) match_sh_reg[15:8] <= wb;
            if (w_pit) begin
                pit_sh_reg.interval <= wb[PIT_IV_MSB:PIT_IV_LSB];
                pit_sh_reg.on       <= wb[BIT_PIT_ON];
            end
        end
    end

    // ------------------------------------------------------------
    // sync channels: a write is applied on the second counter tick
    // ------------------------------------------------------------
    // a new write while busy restarts the wait; software should not
    // do that, but the last value written then still wins
    for (genvar g = 0; g < NUM_CH; g++) begin : g_sync
        assign apply[g] = busy_reg[g] & src_tick & ~chan_wr[g]
                          & (lat_reg[g] == SYNC_LAT - 2'h1);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                busy_reg[g] <= 1'b0;
                lat_reg[g]  <= 2'h0;
            end else if (chan_wr[g]) begin
                busy_reg[g] <= 1'b1;
                lat_reg[g]  <= 2'h0;
            end else if (apply[g]) begin
                busy_reg[g] <= 1'b0;
                lat_reg[g]  <= 2'h0;
            end else if (busy_reg[g] && src_tick) begin
                lat_reg[g]  <= lat_reg[g] + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // counter, wrap and match
    // ------------------------------------------------------------
    wire at_top   = count_reg == top_act_reg;
    wire wrap_ev  = cnt_tick & ~apply[CH_CNT] & at_top;
    wire match_ev = cnt_tick & ~apply[CH_CNT]
                    & (count_reg == match_act_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg     <= CNT_RST;
            top_act_reg   <= TOP_RST;
            match_act_reg <= MATCH_RST;
        end else begin
            if (apply[CH_CNT])
                count_reg <= cnt_sh_reg;
            else if (cnt_tick)
                count_reg <= at_top ? 16'h0000 : count_reg + 16'h0001;
            if (apply[CH_TOP])
                top_act_reg <= top_sh_reg;
            if (apply[CH_MATCH])
                match_act_reg <= match_sh_reg;
        end
    end

    // ------------------------------------------------------------
    // periodic timer
    // ------------------------------------------------------------
    wire pit_run = pit_act_reg.on & ~(debug_halt & ~run_halt_reg);
    wire iv_ok   = pit_act_reg.interval != IV_OFF
                   && pit_act_reg.interval <= IV_MAX;
    wire [DIV_W-1:0] mask = iv_mask(pit_act_reg.interval);
    wire pit_ev = pit_run & src_tick & iv_ok
                  & ((div_reg & mask) == mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pit_act_reg <= '0;
            div_reg     <= '0;
        end else begin
            if (apply[CH_PIT])
                pit_act_reg <= pit_sh_reg;
            if (!pit_act_reg.on)
                div_reg <= '0;
            else if (pit_run && src_tick)
                div_reg <= div_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // interrupt flags: set wins over a same-cycle clear
    // ------------------------------------------------------------
    wire [1:0] flag_set = {match_ev, wrap_ev};
    wire [1:0] flag_clr = w_flag ? wb[1:0] : 2'b00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg     <= 2'b00;
            pit_flag_reg <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            flag_reg     <= (flag_reg & ~flag_clr) | flag_set;
            pit_flag_reg <= (pit_flag_reg & ~(w_pflag & wb[0]))
                            | pit_ev;
            irq_reg      <= |(flag_reg & irq_en_reg)
                            | (pit_flag_reg & pit_ien_reg);
        end
    end

    assign irq = irq_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [1:0] cnt_ticks_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_ticks_reg <= 2'h0;
        else if (chan_wr[CH_CNT])
            cnt_ticks_reg <= 2'h0;
        else if (src_tick && cnt_ticks_reg != 2'h3)
            cnt_ticks_reg <= cnt_ticks_reg + 2'h1;
    end

    sequence s_cnt_write;
        chan_wr[CH_CNT] ##1 busy_reg[CH_CNT];
    endsequence
    property p_cnt_sync;
        apply[CH_CNT] |-> cnt_ticks_reg == 2'h1
                          ##1 count_reg == $past(cnt_sh_reg);
    endproperty
    a_cnt_sync: assert property (p_cnt_sync) else $error("count latency");
    property p_cnt_busy;
        chan_wr[CH_CNT] |-> s_cnt_write;
    endproperty
    a_cnt_busy: assert property (p_cnt_busy) else $error("count busy");
    property p_top_sync;
        apply[CH_TOP] |=> top_act_reg == $past(top_sh_reg);
    endproperty
    a_top_sync: assert property (p_top_sync) else $error("top apply");
    property p_wrap;
        wrap_ev |=> count_reg == 16'h0000 && flag_reg[BIT_WRAP];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap failed");
    property p_stopped;
        !counter_on_reg && !apply[CH_CNT] |=> $stable(count_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count ran");
    property p_iv_off;
        pit_act_reg.interval == IV_OFF || !pit_act_reg.on |-> !pit_ev;
    endproperty
    a_iv_off: assert property (p_iv_off) else $error("stray event");
    property p_pit_busy;
        w_pit |=> busy_reg[CH_PIT];
    endproperty
    a_pit_busy: assert property (p_pit_busy) else $error("pit busy");
    property p_pit_irq;
        pit_ev && pit_ien_reg |=> pit_flag_reg ##1 irq;
    endproperty
    a_pit_irq: assert property (p_pit_irq) else $error("pit irq");
    property p_halt;
        debug_halt && !run_halt_reg |=> $stable(div_reg);
    endproperty
    a_halt: assert property (p_halt) else $error("ran in halt");
    property p_match;
        match_ev && irq_en_reg[BIT_MATCH] |=> flag_reg[BIT_MATCH] ##1 irq;
    endproperty
    a_match: assert property (p_match) else $error("match irq");
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rtc_pkg::*;

    // ----------------------------------------------------------------
    // stimulus and bookkeeping
    // ----------------------------------------------------------------
    logic        pclk       = 1'b0;
    logic        presetn    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic [3:0]  osc_clk_in = 4'h0;
    logic        debug_halt = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [32:0] exp_q[$];
    logic [7:0]  v;
    logic [15:0] c;
    int          seed;
    int          n_mismatch = 0;
    int          checks     = 0;
    logic [5:0]  rst_idx[8] = '{IDX_CNT_LO, IDX_CNT_HI, IDX_TOP_LO,
        IDX_TOP_HI, IDX_MATCH_LO, IDX_MATCH_HI, IDX_PIT_CTRL, IDX_PIT_FLAG};
    logic [7:0]  rst_val[8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
        8'h00, 8'h00};

    always #25 pclk = ~pclk;

    rtc_top uut (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .osc_clk_in (osc_clk_in),
        .debug_halt (debug_halt),
        .irq        (irq)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic cmp(input string what, input logic [32:0] e,
                       input logic [32:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_irq(input logic e);
        checks++;
        if (irq !== e) begin
            n_mismatch++;
            $display("unexpected irq: expected %b seen %b", e, irq);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // read results are queued here and judged by the monitor below
    task automatic apb(input logic wr, input logic [5:0] idx,
                       input logic [7:0] d, input logic err);
        if (!wr) exp_q.push_back({err, 24'h0, d});
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 1'b0);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b0, idx, d, 1'b0);
    endtask

    // slow source clocks only toggle here, so tick counts are exact
    task automatic tick(input int s, input int n);
        repeat (n) begin
            osc_clk_in[s] <= 1'b1;
            repeat (4) @(posedge pclk);
            osc_clk_in[s] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    task automatic sync_wr(input logic [5:0] idx, input logic [7:0] d);
        wr(idx, d);
        tick(3, 2);
    endtask

    task automatic chk_irq(input logic e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        cmp_irq(e);
        @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite
            && exp_q.size() > 0) begin
            cmp("read", exp_q.pop_front(), {pslverr, prdata});
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 27368;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rst_idx[i]) rd(rst_idx[i], rst_val[i]);
        apb(1'b0, 6'h3F, 8'h00, 1'b1);
        // nonzero low byte keeps the count clear of the zero match value
        v = 8'($random(seed)) | 8'h01;
        wr(IDX_CNT_LO, v);
        rd(IDX_STATUS, 8'h02);
        tick(0, 1);
        rd(IDX_CNT_LO, 8'h00);
        tick(0, 1);
        rd(IDX_STATUS, 8'h00);
        rd(IDX_CNT_LO, v);
        c = {8'h00, v};
        v = 8'($random(seed));
        wr(IDX_TOP_LO, v);
        rd(IDX_STATUS, 8'h04);
        tick(0, 2);
        rd(IDX_STATUS, 8'h00);
        rd(IDX_TOP_LO, v);
        wr(IDX_CTRL, 8'h01);
        for (int s = 0; s < 4; s++) begin
            wr(IDX_SRC, 8'(s));
            tick((s + 1) % 4, 2);
            tick(s, 3);
            c = c + 16'h0003;
            rd(IDX_CNT_LO, c[7:0]);
            rd(IDX_CNT_HI, c[15:8]);
        end
        wr(IDX_CTRL, 8'h00);
        tick(3, 2);
        rd(IDX_CNT_LO, c[7:0]);
        sync_wr(IDX_CNT_LO, 8'h05);
        sync_wr(IDX_CNT_HI, 8'h00);
        sync_wr(IDX_TOP_LO, 8'h07);
        sync_wr(IDX_TOP_HI, 8'h00);
        wr(IDX_IRQ_EN, 8'h01);
        wr(IDX_CTRL, 8'h01);
        tick(3, 2);
        rd(IDX_IRQ_FLAG, 8'h00);
        chk_irq(1'b0);
        tick(3, 1);
        rd(IDX_CNT_LO, 8'h00);
        rd(IDX_IRQ_FLAG, 8'h01);
        chk_irq(1'b1);
        tick(3, 1);
        rd(IDX_IRQ_FLAG, 8'h03);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_IRQ_FLAG, 8'h01);
        rd(IDX_IRQ_FLAG, 8'h02);
        chk_irq(1'b0);
        wr(IDX_IRQ_EN, 8'h03);
        chk_irq(1'b1);
        wr(IDX_IRQ_FLAG, 8'h02);
        chk_irq(1'b0);
        wr(IDX_PIT_IEN, 8'h01);
        for (int k = 1; k < 4; k++) begin
            wr(IDX_PIT_CTRL, {1'b0, 4'(k), 3'b001});
            rd(IDX_PIT_STAT, 8'h01);
            tick(3, 2);
            rd(IDX_PIT_STAT, 8'h00);
            wr(IDX_PIT_FLAG, 8'h01);
            // divider starts from zero, so the event lands on the last tick
            tick(3, 2 ** (k + 1) - 1);
            rd(IDX_PIT_FLAG, 8'h00);
            tick(3, 1);
            rd(IDX_PIT_FLAG, 8'h01);
            // switching off clears the divider for the next interval
            if (k < 3) sync_wr(IDX_PIT_CTRL, 8'h00);
        end
        chk_irq(1'b1);
        wr(IDX_PIT_IEN, 8'h00);
        chk_irq(1'b0);
        wr(IDX_PIT_FLAG, 8'h00);
        rd(IDX_PIT_FLAG, 8'h01);
        debug_halt <= 1'b1;
        wr(IDX_PIT_FLAG, 8'h01);
        tick(3, 16);
        rd(IDX_PIT_FLAG, 8'h00);
        wr(IDX_PIT_DBG, 8'h01);
        tick(3, 16);
        rd(IDX_PIT_FLAG, 8'h01);
        debug_halt <= 1'b0;
        // interval off, reserved interval, then timer off
        for (int j = 0; j < 3; j++) begin
            wr(IDX_PIT_CTRL, (j == 0) ? 8'h01 : (j == 1) ? 8'h79 : 8'h08);
            tick(3, 2);
            wr(IDX_PIT_FLAG, 8'h01);
            tick(3, 8);
            rd(IDX_PIT_FLAG, 8'h00);
        end
        report_and_stop();
    end
endmodule
